// ---- pkg/bicb_pkg.sv ----
// package: settings, states and carriers of the chatter blocker
package bicb_pkg;
   // timing base: one tick per millisecond at 25 MHz
   localparam int CLK_HZ = 25000000;
   localparam int MS_PER_S = 1000;
   localparam int S_PER_MIN = 60;
   localparam int TICK_MS = 1;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int CHG_W = 8;
   localparam int TEST_W = 8;
   localparam int SEC_W = 16;
   localparam int MIN_W = 8;
   // chatter-test count value that means unlimited
   localparam logic [7:0] TESTS_UNLIMITED = 8'hFF;
   localparam logic [7:0] CNT_RESET = 8'h00;

   typedef enum logic [3:0] {
      BICB_IDLE = 4'h1,
      BICB_TEST = 4'h2,
      BICB_HOLD = 4'h4,
      BICB_PERM = 4'h8
   } bicb_state_t;

   typedef struct packed {
      logic [CHG_W-1:0] perm_changes;
      logic [SEC_W-1:0] init_test_s;
      logic [TEST_W-1:0] num_tests;
      logic [MIN_W-1:0] idle_min;
      logic [SEC_W-1:0] subs_test_s;
   } bicb_cfg_t;
endpackage : bicb_pkg

// ---- hw/bicb_filter.sv ----
// chatter blocker for a bank of relay binary inputs
//
// Behaviour
// - count changes in initial window, compare limit
// - zero permissible changes disables blocking
// - initial window starts on first activation
// - test count sets cycles before final block
// - unlimited test count never blocks permanently
// - exceeded window starts idle interval, blocked
// - idle, subsequent times used only if tests nonzero
// - subsequent window follows idle, counts again
// - pass releases, fail restarts idle until limit
// - shared settings, per-input enable
// - protective indications cannot be chatter-blocked
// - blocked input flags indication and common report
// - single-point frozen on if was active
// - single-point frozen off if was inactive
// - double-point chatter reports intermediate
`timescale 1ns/1ps
module bicb_filter #(
   parameter int N = 8,
   parameter int TICK_CYCLES = bicb_pkg::TICK_CYC
)(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // settings
   input wire bicb_pkg::bicb_cfg_t cfg_in,
   input wire logic [N-1:0] enable_in,
   input wire logic [N-1:0] protective_in,
   input wire logic [N-1:0] double_point_in,
   // contacts from field pins
   input wire logic [N-1:0] contact_in,
   // filtered indications
   output logic [N-1:0] indication_out,
   output logic [N-1:0] intermediate_out,
   output logic [N-1:0] chatter_blocked_flag_out,
   output logic chatter_report_out
);
   // refuse sizes the logic cannot serve
   if (N < 1 || TICK_CYCLES < 1)
   begin : bad_param
      $error("bicb_filter: bad parameter");
   end

   localparam int TW = 32;

   function automatic logic [TW-1:0] ms_of_s(input logic [15:0] s);
      ms_of_s = TW'(s) * TW'(bicb_pkg::MS_PER_S);
   endfunction : ms_of_s

   logic [N-1:0] sync1_r;
   logic [N-1:0] sync2_r;
   logic [N-1:0] prev_r;
   logic [31:0] pre_r;
   logic tick_r;

   // two-flop synchroniser on the field contacts
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
         prev_r <= '0;
      end
      else
      begin
         sync1_r <= contact_in;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   // millisecond tick prescaler
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         pre_r <= '0;
         tick_r <= 1'b0;
      end
      else if (pre_r == 32'(TICK_CYCLES - 1))
      begin
         pre_r <= '0;
         tick_r <= 1'b1;
      end
      else
      begin
         pre_r <= pre_r + 32'h1;
         tick_r <= 1'b0;
      end
   end

   wire logic [N-1:0] edge_w = sync2_r ^ prev_r;
   wire logic zero_chg = (cfg_in.perm_changes == '0);
   wire logic [TW-1:0] init_ms = ms_of_s(cfg_in.init_test_s);
   wire logic [TW-1:0] subs_ms = ms_of_s(cfg_in.subs_test_s);
   wire logic [TW-1:0] idle_ms = TW'(cfg_in.idle_min) *
      TW'(bicb_pkg::S_PER_MIN * bicb_pkg::MS_PER_S);

   bicb_pkg::bicb_state_t st_r [N];
   logic [bicb_pkg::CHG_W:0] chg_r [N];
   logic [bicb_pkg::TEST_W-1:0] cyc_r [N];
   logic [TW-1:0] tmr_r [N];
   logic [N-1:0] held_r;
   logic [N-1:0] frozen_r;

   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : ch
         // an input that may be blocked at all
         wire logic act = enable_in[g] & ~protective_in[g]
            & ~zero_chg;
         wire logic over = chg_r[g] >
            {1'b0, cfg_in.perm_changes};
         wire logic expired = (tmr_r[g] == '0);
         wire logic blocked = (st_r[g] == bicb_pkg::BICB_HOLD)
            | (st_r[g] == bicb_pkg::BICB_PERM)
            | ((st_r[g] == bicb_pkg::BICB_TEST) & (cyc_r[g] != '0));
         // tests zero: idle and subsequent times never come into play
         wire logic no_tests = (cfg_in.num_tests == '0);
         wire logic limit_hit = (cfg_in.num_tests !=
            bicb_pkg::TESTS_UNLIMITED)
            & (cyc_r[g] >= cfg_in.num_tests);

         always_ff @(posedge clk_in or posedge rst_in)
         begin
            if (rst_in)
            begin
               st_r[g] <= bicb_pkg::BICB_IDLE;
               chg_r[g] <= '0;
               cyc_r[g] <= bicb_pkg::CNT_RESET;
               tmr_r[g] <= '0;
            end
            else if (!act)
            begin
               st_r[g] <= bicb_pkg::BICB_IDLE;
               chg_r[g] <= '0;
               cyc_r[g] <= bicb_pkg::CNT_RESET;
               tmr_r[g] <= '0;
            end
            else
            begin
               case (st_r[g])
                  bicb_pkg::BICB_IDLE:
                  begin
                     // window opens on first activation
                     if (edge_w[g] & sync2_r[g])
                     begin
                        st_r[g] <= bicb_pkg::BICB_TEST;
                        chg_r[g] <= '0;
                        tmr_r[g] <= init_ms;
                     end
                  end
                  bicb_pkg::BICB_TEST:
                  begin
                     if (edge_w[g] & ~over)
                     begin
                        chg_r[g] <= chg_r[g]
                           + (bicb_pkg::CHG_W + 1)'(1);
                     end
                     if (over)
                     begin
                        // failed window uses up one test cycle
                        if (no_tests | limit_hit)
                        begin
                           st_r[g] <= bicb_pkg::BICB_PERM;
                        end
                        else
                        begin
                           st_r[g] <= bicb_pkg::BICB_HOLD;
                           tmr_r[g] <= idle_ms;
                           // saturate so an unlimited count never wraps
                           if (cyc_r[g] != '1)
                           begin
                              cyc_r[g] <= cyc_r[g]
                                 + (bicb_pkg::TEST_W)'(1);
                           end
                        end
                     end
                     else if (expired)
                     begin
                        // pass: release and forget history
                        st_r[g] <= bicb_pkg::BICB_IDLE;
                        cyc_r[g] <= bicb_pkg::CNT_RESET;
                     end
                     else if (tick_r)
                     begin
                        tmr_r[g] <= tmr_r[g] - TW'(1);
                     end
                  end
                  bicb_pkg::BICB_HOLD:
                  begin
                     if (expired)
                     begin
                        st_r[g] <= bicb_pkg::BICB_TEST;
                        chg_r[g] <= '0;
                        tmr_r[g] <= subs_ms;
                     end
                     else if (tick_r)
                     begin
                        tmr_r[g] <= tmr_r[g] - TW'(1);
                     end
                  end
                  bicb_pkg::BICB_PERM:
                  begin
                     st_r[g] <= bicb_pkg::BICB_PERM;
                  end
                  default:
                  begin
                     st_r[g] <= bicb_pkg::BICB_IDLE;
                  end
               endcase
            end
         end

         // freeze the indication at the level held when blocking began
         always_ff @(posedge clk_in or posedge rst_in)
         begin
            if (rst_in)
            begin
               held_r[g] <= 1'b0;
               frozen_r[g] <= 1'b0;
            end
            else if (blocked & ~frozen_r[g])
            begin
               frozen_r[g] <= 1'b1;
               held_r[g] <= prev_r[g];
            end
            else if (!blocked)
            begin
               frozen_r[g] <= 1'b0;
            end
         end

         always_ff @(posedge clk_in or posedge rst_in)
         begin
            if (rst_in)
            begin
               indication_out[g] <= 1'b0;
               intermediate_out[g] <= 1'b0;
               chatter_blocked_flag_out[g] <= 1'b0;
            end
            else
            begin
               chatter_blocked_flag_out[g] <= blocked;
               intermediate_out[g] <= blocked
                  & double_point_in[g];
               if (!blocked)
               begin
                  indication_out[g] <= sync2_r[g];
               end
               else if (double_point_in[g])
               begin
                  indication_out[g] <= 1'b0;
               end
               else
               begin
                  indication_out[g] <= frozen_r[g] ? held_r[g]
                     : prev_r[g];
               end
            end
         end

         prot_never_a: assert property (@(posedge clk_in)
            disable iff (rst_in)
            protective_in[g] ##1 protective_in[g]
            |=> !chatter_blocked_flag_out[g])
            else $error("protective input flagged");
         zero_off_a: assert property (@(posedge clk_in)
            disable iff (rst_in)
            (cfg_in.perm_changes == '0) |=> st_r[g] == bicb_pkg::BICB_IDLE)
            else $error("blocking active with zero setting");
         over_hold_a: assert property (@(posedge clk_in)
            disable iff (rst_in)
            (act && st_r[g] == bicb_pkg::BICB_TEST && over
             && !no_tests && !limit_hit)
            |=> st_r[g] == bicb_pkg::BICB_HOLD)
            else $error("exceeded count did not start idle");
         perm_stay_a: assert property (@(posedge clk_in)
            disable iff (rst_in)
            (act && st_r[g] == bicb_pkg::BICB_PERM)
            |=> st_r[g] == bicb_pkg::BICB_PERM || !$past(act))
            else $error("permanent block left");
         unlim_never_a: assert property (@(posedge clk_in)
            disable iff (rst_in)
            (cfg_in.num_tests == bicb_pkg::TESTS_UNLIMITED
             && st_r[g] != bicb_pkg::BICB_PERM)
            |=> st_r[g] != bicb_pkg::BICB_PERM)
            else $error("unlimited tests blocked permanently");
         hold_test_a: assert property (@(posedge clk_in)
            disable iff (rst_in)
            (act && st_r[g] == bicb_pkg::BICB_HOLD && expired)
            |=> st_r[g] == bicb_pkg::BICB_TEST && chg_r[g] == '0)
            else $error("subsequent window did not open");
         release_a: assert property (@(posedge clk_in)
            disable iff (rst_in)
            (act && st_r[g] == bicb_pkg::BICB_TEST && !over && expired)
            |=> st_r[g] == bicb_pkg::BICB_IDLE && cyc_r[g] == '0)
            else $error("release did not clear cycles");
         flag_dp_a: assert property (@(posedge clk_in)
            disable iff (rst_in)
            (blocked && double_point_in[g])
            |=> intermediate_out[g] && chatter_blocked_flag_out[g])
            else $error("double point not intermediate");
         start_edge_a: assert property (@(posedge clk_in)
            disable iff (rst_in)
            (act && st_r[g] == bicb_pkg::BICB_IDLE && !(edge_w[g]
             && sync2_r[g])) |=> st_r[g] == bicb_pkg::BICB_IDLE)
            else $error("window opened without activation");
      end
   endgenerate

   // common chatter report
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         chatter_report_out <= 1'b0;
      end
      else
      begin
         chatter_report_out <= |chatter_blocked_flag_out;
      end
   end

   common_rep_a: assert property (@(posedge clk_in)
      disable iff (rst_in)
      chatter_report_out == $past(|chatter_blocked_flag_out))
      else $error("common report mismatch");
endmodule : bicb_filter

// ---- tb/bicb_contacts.sv ----
// field contacts driving the relay binary inputs
`timescale 1ns/1ps
module bicb_contacts #(
   parameter int N = 4
)(
   // clock
   input wire logic clk_in,
   // contacts toward the relay
   output logic [N-1:0] contact_out
);
   initial contact_out = '0;

   // selected contacts bounce together; gap sets prompt or slow bouncing
   task automatic chatter(input logic [N-1:0] sel, input int edges,
                          input int gap);
      repeat (edges)
      begin
         repeat (gap) @(posedge clk_in);
         #1 contact_out = contact_out ^ sel;
      end
   endtask : chatter

   task automatic open_all();
      @(posedge clk_in);
      #1 contact_out = '0;
   endtask : open_all
endmodule : bicb_contacts

// ---- tb/testbench.sv ----
// directed bench for the chatter blocker
`timescale 1ns/1ps
module testbench;
   localparam int N = 4;
   logic clk_in;
   logic rst_in;
   bicb_pkg::bicb_cfg_t cfg_in;
   logic [N-1:0] enable_in;
   logic [N-1:0] protective_in;
   logic [N-1:0] double_point_in;
   logic [N-1:0] contact;
   logic [N-1:0] indication_out;
   logic [N-1:0] intermediate_out;
   logic [N-1:0] chatter_blocked_flag_out;
   logic chatter_report_out;
   int n_fail = 0;
   int comparisons = 0;

   // one tick a cycle: a minute of idle is 60000 cycles
   bicb_filter #(.N(N), .TICK_CYCLES(1)) dut (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .cfg_in(cfg_in),
      .enable_in(enable_in),
      .protective_in(protective_in),
      .double_point_in(double_point_in),
      .contact_in(contact),
      .indication_out(indication_out),
      .intermediate_out(intermediate_out),
      .chatter_blocked_flag_out(chatter_blocked_flag_out),
      .chatter_report_out(chatter_report_out)
   );

   bicb_contacts #(.N(N)) field (.clk_in(clk_in), .contact_out(contact));

   initial
   begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   task automatic check(input string what, input logic [N:0] seen,
                        input logic [N:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic observe(input logic [N-1:0] f, input logic [N-1:0] ind,
                          input logic [N-1:0] im);
      check("flags", {chatter_report_out, chatter_blocked_flag_out},
            {|f, f});
      check("indication", {1'b0, indication_out},
            {1'b0, ind});
      check("intermediate", {1'b0, intermediate_out},
            {1'b0, im});
   endtask : observe

   task automatic cycles(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : cycles

   // dropping every enable returns all inputs to idle between tests
   task automatic setup(input logic [7:0] perm, input logic [7:0] tests,
                        input logic [N-1:0] en, input logic [N-1:0] prot,
                        input logic [N-1:0] dbl);
      enable_in = '0;
      field.open_all();
      cycles(6);
      cfg_in.perm_changes = perm;
      cfg_in.num_tests = tests;
      protective_in = prot;
      double_point_in = dbl;
      enable_in = en;
      cycles(2);
   endtask : setup

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run

   initial
   begin
      repeat (90000) @(posedge clk_in);
      n_fail++;
      complete_run();
   end

   initial
   begin
      rst_in = 1'b1;
      cfg_in = '{perm_changes: 8'h03, init_test_s: 16'h0001,
                 num_tests: 8'h00, idle_min: 8'h01, subs_test_s: 16'h0001};
      enable_in = '0;
      protective_in = '0;
      double_point_in = '0;
      cycles(16);
      observe(4'h0, 4'h0, 4'h0);
      rst_in = 1'b0;
      $display("test reset done");
      // the opening rise is not counted, so edge five exceeds three
      setup(8'h03, 8'h00, 4'h7, 4'h2, 4'h0);
      field.chatter(4'h7, 5, 10);
      cycles(10);
      observe(4'h5, 4'h7, 4'h0);
      field.chatter(4'h7, 1, 10);
      cycles(10);
      observe(4'h5, 4'h5, 4'h0);
      cycles(3000);
      observe(4'h5, 4'h5, 4'h0);
      // no test cycles: the first failure blocks for good
      check("state", {1'b0, dut.st_r[0]},
            {1'b0, bicb_pkg::BICB_PERM});
      $display("test single point on done");
      setup(8'h02, 8'h00, 4'h9, 4'h0, 4'h8);
      field.chatter(4'hB, 4, 10);
      field.chatter(4'hB, 1, 10);
      cycles(10);
      observe(4'h9, 4'h2, 4'h8);
      $display("test single point off and double point done");
      setup(8'h00, 8'h00, 4'hF, 4'h0, 4'h0);
      field.chatter(4'h1, 9, 10);
      cycles(10);
      observe(4'h0, 4'h1, 4'h0);
      $display("test disabled blocking done");
      // input 1 fails its subsequent window, input 0 passes it
      setup(8'h03, 8'h02, 4'h3, 4'h0, 4'h0);
      field.chatter(4'h3, 4, 10);
      cycles(10);
      observe(4'h0, 4'h0, 4'h0);
      cycles(1100);
      field.chatter(4'h3, 5, 10);
      cycles(10);
      observe(4'h3, 4'h3, 4'h0);
      cycles(59000);
      observe(4'h3, 4'h3, 4'h0);
      cycles(1000);
      field.chatter(4'h2, 5, 10);
      cycles(1200);
      observe(4'h2, 4'h3, 4'h0);
      check("state", {1'b0, dut.st_r[1]},
            {1'b0, bicb_pkg::BICB_HOLD});
      $display("test idle and subsequent window done");
      setup(8'h03, 8'hFF, 4'h1, 4'h0, 4'h0);
      field.chatter(4'h1, 5, 10);
      cycles(10);
      observe(4'h1, 4'h1, 4'h0);
      // an unlimited count idles instead of blocking for good
      check("state", {1'b0, dut.st_r[0]},
            {1'b0, bicb_pkg::BICB_HOLD});
      $display("test unlimited test count done");
      complete_run();
   end
endmodule : testbench
